// File: rtl/tdmsr_pkg.sv
/*
 * tdmsr_pkg: constants and types shared by the slot router and its fifo.
 * Assumes a single 10 MHz system clock; line clocks are much slower pins.
 */
package tdmsr_pkg;
    localparam int CLK_HZ        = 10_000_000;
    localparam int NUM_TDM       = 2;
    localparam int NUM_CHAN      = 64;
    localparam int CHAN_W        = 6;
    localparam int NUM_ENTRY     = 64;
    localparam int ENTRY_W       = 6;
    localparam int CNT_W         = 4;
    // routing entry field layout
    localparam int ENT_LOOP_BIT  = 15;
    localparam int ENT_LAST_BIT  = 14;
    localparam int ENT_BYTE_BIT  = 13;
    localparam int ENT_STRB_BIT  = 12;
    localparam int ENT_SKIP_BIT  = 11;
    localparam int ENT_CNT_LSB   = 6;
    localparam int ENT_CH_LSB    = 0;
    localparam logic [15:0] ENT_RESET = 16'h4000;
    localparam int FIFO_W        = 8;
    localparam int FIFO_DEPTH    = 16;
    localparam int FIFO_AW       = 4;
    typedef enum logic [1:0] {TDMSR_HUNT, TDMSR_RUN, TDMSR_END} tdmsr_state_t;
endpackage : tdmsr_pkg

// File: rtl/tdmsr_fifo.sv
/*
 * tdmsr_fifo: small synchronous fifo with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module tdmsr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    // honest full and empty straight from the occupancy count
    assign in_ready  = (cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage array, written only on accepted pushes
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule : tdmsr_fifo

// File: rtl/tdmsr_router.sv
/*
 * tdmsr_router: time slot assigner for two tdm line interfaces feeding one
 * multichannel serial channel controller. Routing tables are written through
 * a plain table-write port; received bits are packed into bytes tagged with
 * their logical channel and queued in a fifo toward the comms processor.
 * Assumes line clocks and syncs are slow pins sampled by CLOCK (10 MHz);
 * protocol work (hdlc, descriptors, interrupt queue) sits downstream.
 */
`timescale 1ns/1ps
// How it works
// - up to 64 logical channels share one controller across both tdm lines
// - per channel bit selects hdlc framing or transparent pass-through
// - frame sync starts clock counting and restarts the table at entry zero
// - entries route bit or byte groups, including skipped spans, to channels
// - two independent assigners, each with own clocks and frame syncs
// - any channel maps to any slot; receive and transmit tables are separate
// - multiplexed mode resynchronises on every frame
// - unmultiplexed mode syncs once on carrier/clear-to-send pulses until restart
// - bit 15 of each receive entry enables loopback for that slot
// - loopback feeds transmit bits to receive in the same slot
// - echo mode copies receive pin to transmit pin; receiver keeps working
// - optional level inversion of transmit and receive data
// - strobe output asserted during a chosen entry's slot
// - controller only serialises and buffers; no protocol work here
// - no transfers for inactive channels or idle transmit channels
// - receive byte queue overflow is flagged
// - missed clock skips next sync; extra clock resumes at next sync
module tdmsr_router
    import tdmsr_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire logic                RST,
    input  wire logic [NUM_TDM-1:0]  RX_CLK_PIN,
    input  wire logic [NUM_TDM-1:0]  TX_CLK_PIN,
    input  wire logic [NUM_TDM-1:0]  RX_SYNC_PIN,
    input  wire logic [NUM_TDM-1:0]  TX_SYNC_PIN,
    input  wire logic [NUM_TDM-1:0]  LINE_RECEIVE_PIN,
    output logic [NUM_TDM-1:0]       LINE_TRANSMIT_PIN,
    output logic [NUM_TDM-1:0]       STROBE_PIN,
    input  wire logic                UNMUX_MODE,
    input  wire logic                UNMUX_CD_PIN,
    input  wire logic                UNMUX_CTS_PIN,
    input  wire logic                RESTART,
    input  wire logic [NUM_TDM-1:0]  ECHO_EN,
    input  wire logic                INV_TX,
    input  wire logic                INV_RX,
    input  wire logic                TBL_WE,
    input  wire logic                TBL_TX,
    input  wire logic                TBL_TDM,
    input  wire logic [ENTRY_W-1:0]  TBL_ADDR,
    input  wire logic [15:0]         TBL_DATA,
    input  wire logic                CHAN_WE,
    input  wire logic [CHAN_W-1:0]   CHAN_ADDR,
    input  wire logic                CHAN_ACTIVE,
    input  wire logic                CHAN_HDLC,
    input  wire logic [NUM_TDM-1:0]  TX_DATA_AVAIL,
    input  wire logic                TX_BIT,
    output logic [NUM_TDM-1:0]       TX_BIT_REQ,
    output logic [CHAN_W-1:0]        TX_BIT_CHAN,
    output logic [FIFO_W-1:0]        RX_BYTE,
    output logic [CHAN_W-1:0]        RX_BYTE_CHAN,
    output logic                     RX_BYTE_HDLC,
    output logic                     RX_BYTE_VALID,
    input  wire logic                RX_BYTE_READY,
    output logic [NUM_TDM-1:0]       RX_SYNCED,
    output logic                     RX_OVERFLOW
);
    localparam int QW = FIFO_W + CHAN_W + 1;

    logic [15:0]           rx_tbl [NUM_TDM][NUM_ENTRY];
    logic [15:0]           tx_tbl [NUM_TDM][NUM_ENTRY];
    logic [NUM_CHAN-1:0]   chan_active;
    logic [NUM_CHAN-1:0]   chan_hdlc;
    logic                  cd_s1, cd_s2, cd_s3;
    logic                  cts_s1, cts_s2, cts_s3;
    logic                  unmux_rx_go;
    logic                  unmux_tx_go;
    logic [QW-1:0]         q_in;
    logic                  q_valid;
    logic                  q_ready;
    logic [QW-1:0]         q_out;
    logic                  q_out_valid;
    logic [NUM_TDM-1:0]    byte_done;
    logic [FIFO_W-1:0]     byte_val [NUM_TDM];
    logic [CHAN_W-1:0]     byte_ch [NUM_TDM];
    logic [NUM_TDM-1:0]    tx_req;
    logic [NUM_TDM-1:0]    tx_pin;
    logic [NUM_TDM-1:0]    tx_cur;
    logic [NUM_TDM-1:0]    strobe;
    logic [NUM_TDM-1:0]    synced;

    // bit count carried by one entry: bytes count eight bits each
    function automatic logic [CNT_W+3:0] ent_bits(input logic [15:0] e);
        logic [CNT_W+3:0] n;
        n = {4'h0, e[ENT_CNT_LSB +: CNT_W]} + 1'b1;
        ent_bits = e[ENT_BYTE_BIT] ? (CNT_W+4)'(n << 3) : n;
    endfunction : ent_bits

    // receive and transmit routing table writes; tables stay live so entries may change per frame
    always_ff @(posedge CLOCK) begin
        if (TBL_WE && !TBL_TX) begin
            rx_tbl[TBL_TDM][TBL_ADDR] <= TBL_DATA;
        end
        if (TBL_WE && TBL_TX) begin
            tx_tbl[TBL_TDM][TBL_ADDR] <= TBL_DATA;
        end
    end

    // per-channel activity and framing choice
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            chan_active <= '0;
            chan_hdlc   <= '0;
        end else if (CHAN_WE) begin
            chan_active[CHAN_ADDR] <= CHAN_ACTIVE;
            chan_hdlc[CHAN_ADDR]   <= CHAN_HDLC;
        end
    end

    // unmultiplexed mode: one-shot sync on carrier detect and clear-to-send pulses
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            {cd_s1, cd_s2, cd_s3}    <= 3'h0;
            {cts_s1, cts_s2, cts_s3} <= 3'h0;
        end else begin
            cd_s1  <= UNMUX_CD_PIN;
            cd_s2  <= cd_s1;
            cd_s3  <= cd_s2;
            cts_s1 <= UNMUX_CTS_PIN;
            cts_s2 <= cts_s1;
            cts_s3 <= cts_s2;
        end
    end
    assign unmux_rx_go = cd_s2 && !cd_s3;
    assign unmux_tx_go = cts_s2 && !cts_s3;

    // two independent assigners, one per tdm line
    for (genvar t = 0; t < NUM_TDM; t++) begin : g_tdm
        logic [3:0]         rc, tc, rs, ts, rd;
        logic               rc_rise, tc_rise, tc_fall, rs_hi, ts_hi;
        logic               rx_in;
        tdmsr_state_t       rx_st, tx_st;
        logic [ENTRY_W-1:0] rx_ent, tx_ent;
        logic [CNT_W+3:0]   rx_left, tx_left;
        logic [15:0]        re, te;
        logic [2:0]         nbit;
        logic [FIFO_W-1:0]  sh;
        logic               one_shot_rx, one_shot_tx;

        // three-flop synchronisers then an edge flop; only stage three onward is read
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                rc <= 4'h0; tc <= 4'h0; rs <= 4'h0; ts <= 4'h0; rd <= 4'h0;
            end else begin
                rc <= {rc[2:0], RX_CLK_PIN[t]};
                tc <= {tc[2:0], TX_CLK_PIN[t]};
                rs <= {rs[2:0], RX_SYNC_PIN[t]};
                ts <= {ts[2:0], TX_SYNC_PIN[t]};
                rd <= {rd[2:0], LINE_RECEIVE_PIN[t]};
            end
        end
        assign rc_rise = rc[2] && !rc[3];
        assign tc_rise = tc[2] && !tc[3];
        assign tc_fall = !tc[2] && tc[3];
        assign rs_hi   = rs[2];
        assign ts_hi   = ts[2];
        assign re      = rx_tbl[t][rx_ent];
        assign te      = tx_tbl[t][tx_ent];
        assign one_shot_rx = UNMUX_MODE ? unmux_rx_go : rs_hi;
        assign one_shot_tx = UNMUX_MODE ? unmux_tx_go : ts_hi;

        // receive data: loopback takes this slot's own transmit bit, else the pin
        // the bit requested for this very slot, so the loop does not lag one bit
        assign rx_in = (re[ENT_LOOP_BIT] ? (tx_req[t] ? TX_BIT : 1'b1) : rd[2])
                       ^ INV_RX;

        // receive counter: hunt for sync, walk entries, park at last entry
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                rx_st <= TDMSR_HUNT; rx_ent <= '0; rx_left <= '0;
            end else if (RESTART) begin
                rx_st <= TDMSR_HUNT;
            end else if (rc_rise) begin
                unique case (rx_st)
                    TDMSR_HUNT, TDMSR_END: begin
                        // sync honoured in hunt, and in the end state only in multiplexed mode
                        if (one_shot_rx && !(UNMUX_MODE && rx_st == TDMSR_END)) begin
                            rx_st   <= TDMSR_RUN;
                            rx_ent  <= '0;
                            rx_left <= ent_bits(rx_tbl[t][0]) - 1'b1;
                        end
                    end
                    TDMSR_RUN: begin
                        if (rx_left != '0) begin
                            rx_left <= rx_left - 1'b1;
                        end else if (re[ENT_LAST_BIT]) begin
                            rx_st <= TDMSR_END;
                        end else begin
                            rx_ent  <= rx_ent + 1'b1;
                            rx_left <= ent_bits(rx_tbl[t][rx_ent + 1'b1]) - 1'b1;
                        end
                    end
                endcase
            end
        end

        // byte packer: skipped and inactive spans produce no transfers
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                nbit <= '0; sh <= '0; byte_done[t] <= 1'b0;
                byte_val[t] <= '0; byte_ch[t] <= '0;
            end else begin
                byte_done[t] <= 1'b0;
                if (rc_rise && rx_st == TDMSR_RUN && !re[ENT_SKIP_BIT]
                        && chan_active[re[ENT_CH_LSB +: CHAN_W]]) begin
                    sh   <= {sh[FIFO_W-2:0], rx_in};
                    nbit <= nbit + 1'b1;
                    if (nbit == 3'h7) begin
                        byte_done[t] <= 1'b1;
                        byte_val[t]  <= {sh[FIFO_W-2:0], rx_in};
                        byte_ch[t]   <= re[ENT_CH_LSB +: CHAN_W];
                    end
                end
            end
        end

        // transmit counter mirrors the receive one on transmit clock and sync
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                tx_st <= TDMSR_HUNT; tx_ent <= '0; tx_left <= '0;
            end else if (RESTART) begin
                tx_st <= TDMSR_HUNT;
            end else if (tc_rise) begin
                unique case (tx_st)
                    TDMSR_HUNT, TDMSR_END: begin
                        if (one_shot_tx && !(UNMUX_MODE && tx_st == TDMSR_END)) begin
                            tx_st   <= TDMSR_RUN;
                            tx_ent  <= '0;
                            tx_left <= ent_bits(tx_tbl[t][0]) - 1'b1;
                        end
                    end
                    TDMSR_RUN: begin
                        if (tx_left != '0) begin
                            tx_left <= tx_left - 1'b1;
                        end else if (te[ENT_LAST_BIT]) begin
                            tx_st <= TDMSR_END;
                        end else begin
                            tx_ent  <= tx_ent + 1'b1;
                            tx_left <= ent_bits(tx_tbl[t][tx_ent + 1'b1]) - 1'b1;
                        end
                    end
                endcase
            end
        end

        // transmit bit request only for active channels with data waiting
        assign tx_req[t] = tc_rise && tx_st == TDMSR_RUN && !te[ENT_SKIP_BIT]
                           && chan_active[te[ENT_CH_LSB +: CHAN_W]]
                           && TX_DATA_AVAIL[t];

        // pin driver changes on the falling line clock; idles high when not routed, low when INV_TX is set
        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                tx_pin[t] <= 1'b1; tx_cur[t] <= 1'b1; strobe[t] <= 1'b0;
            end else begin
                if (tx_req[t]) begin
                    tx_cur[t] <= TX_BIT;
                end else if (tc_rise) begin
                    tx_cur[t] <= 1'b1;
                end
                if (tc_fall) begin
                    tx_pin[t] <= ECHO_EN[t] ? rd[2] : (tx_cur[t] ^ INV_TX);
                    strobe[t] <= tx_st == TDMSR_RUN && te[ENT_STRB_BIT];
                end
            end
        end
        assign synced[t] = rx_st != TDMSR_HUNT;
    end : g_tdm

    // line 0 wins when both finish a byte together; second is dropped and flagged
    assign q_valid = byte_done[0] || byte_done[1];
    assign q_in = byte_done[0]
        ? {chan_hdlc[byte_ch[0]], byte_ch[0], byte_val[0]}
        : {chan_hdlc[byte_ch[1]], byte_ch[1], byte_val[1]};

    // elasticity toward the comms processor; protocol handling is downstream
    tdmsr_fifo #(.W(QW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clk       (CLOCK),
        .rst       (RST),
        .in_data   (q_in),
        .in_valid  (q_valid),
        .in_ready  (q_ready),
        .out_data  (q_out),
        .out_valid (q_out_valid),
        .out_ready (RX_BYTE_READY && RX_BYTE_VALID)
    );

    // registered outputs; overflow is sticky until restart
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RX_BYTE <= '0; RX_BYTE_CHAN <= '0; RX_BYTE_HDLC <= 1'b0;
            RX_BYTE_VALID <= 1'b0; RX_OVERFLOW <= 1'b0;
            LINE_TRANSMIT_PIN <= '1; STROBE_PIN <= '0; RX_SYNCED <= '0;
            TX_BIT_REQ <= '0; TX_BIT_CHAN <= '0;
        end else begin
            if (!RX_BYTE_VALID || RX_BYTE_READY) begin
                RX_BYTE_VALID <= q_out_valid && !(RX_BYTE_VALID && RX_BYTE_READY);
                {RX_BYTE_HDLC, RX_BYTE_CHAN, RX_BYTE} <= q_out;
            end
            if ((q_valid && !q_ready) || (byte_done[0] && byte_done[1])) begin
                RX_OVERFLOW <= 1'b1;
            end else if (RESTART) begin
                RX_OVERFLOW <= 1'b0;
            end
            LINE_TRANSMIT_PIN <= tx_pin;
            STROBE_PIN        <= strobe;
            RX_SYNCED         <= synced;
            TX_BIT_REQ        <= tx_req;
            TX_BIT_CHAN       <= tx_req[0] ? tx_tbl[0][g_tdm[0].tx_ent][CHAN_W-1:0]
                                           : tx_tbl[1][g_tdm[1].tx_ent][CHAN_W-1:0];
        end
    end
endmodule : tdmsr_router

// File: bench/tdmsr_line_model.sv
/*
 * tdmsr_line_model: behavioural tdm line transceiver sending one frame per go.
 * Assumes the bench wires its clock and sync to both router directions.
 */
`timescale 1ns/1ps
module tdmsr_line_model (
    input  wire logic        go,
    input  wire logic [23:0] bits,
    input  wire logic [4:0]  nclk,
    output logic             lclk,
    output logic             sync,
    output logic             data,
    output logic             busy
);
    int i;
    initial begin
        lclk = 1'b0;
        sync = 1'b0;
        data = 1'b0;
        busy = 1'b0;
    end
    // sync rise first, then msb-first data changed while the clock is low
    always @(posedge go) begin
        busy = 1'b1;
        #400 sync = 1'b1;
        #400 lclk = 1'b1;
        for (i = 0; i < nclk; i++) begin
            #400 lclk = 1'b0;
            sync = 1'b0;
            data = bits[23-i];
            #400 lclk = 1'b1;
        end
        #400 lclk = 1'b0;
        sync = 1'b0;
        // clock parks low; released line flips so a stale bit never looks valid
        data = ~data;
        busy = 1'b0;
    end
endmodule : tdmsr_line_model

// File: bench/tdmsr_router_sva.sv
/*
 * tdmsr_router_sva: port-level checks on the slot router, bound into it.
 * Assumes line pins move slowly against CLOCK and echo stays off.
 */
`timescale 1ns/1ps
module tdmsr_router_sva
    import tdmsr_pkg::*;
(
    input wire logic               CLOCK,
    input wire logic               RST,
    input wire logic [NUM_TDM-1:0] TX_CLK_PIN,
    input wire logic [NUM_TDM-1:0] RX_SYNC_PIN,
    input wire logic [NUM_TDM-1:0] LINE_TRANSMIT_PIN,
    input wire logic [NUM_TDM-1:0] STROBE_PIN,
    input wire logic               RESTART,
    input wire logic [NUM_TDM-1:0] TX_DATA_AVAIL,
    input wire logic [NUM_TDM-1:0] TX_BIT_REQ,
    input wire logic [FIFO_W-1:0]  RX_BYTE,
    input wire logic [CHAN_W-1:0]  RX_BYTE_CHAN,
    input wire logic               RX_BYTE_HDLC,
    input wire logic               RX_BYTE_VALID,
    input wire logic               RX_BYTE_READY,
    input wire logic [NUM_TDM-1:0] RX_SYNCED,
    input wire logic               RX_OVERFLOW
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    reset_idle_a: assert property ($fell(RST) |-> LINE_TRANSMIT_PIN == 2'b11
        && STROBE_PIN == 2'b00 && !RX_BYTE_VALID && !RX_OVERFLOW)
        else $error("outputs not idle after reset");
    overflow_sticky_a: assert property (RX_OVERFLOW && !RESTART |=> RX_OVERFLOW)
        else $error("overflow flag dropped by itself");
    overflow_when_full_a: assert property ($rose(RX_OVERFLOW) |-> RX_BYTE_VALID
        && !$past(RX_BYTE_READY)) else $error("overflow without a stalled queue");
    restart_clears_a: assert property (RESTART |-> ##[1:2] (RX_SYNCED == 2'b00
        && !RX_OVERFLOW)) else $error("restart left sync or overflow set");
    byte_holds_a: assert property (RX_BYTE_VALID && !RX_BYTE_READY |=> RX_BYTE_VALID
        && $stable(RX_BYTE) && $stable(RX_BYTE_CHAN) && $stable(RX_BYTE_HDLC))
        else $error("queued byte changed before acceptance");
    byte_needs_sync_a: assert property ($rose(RX_BYTE_VALID) |-> RX_SYNCED != 2'b00)
        else $error("byte delivered while hunting");
    sync_starts_frame_a: assert property ($rose(RX_SYNCED[0])
        |-> $past(RX_SYNC_PIN[0], 2)) else $error("synced without a sync pulse");
    req_needs_data_a: assert property (TX_BIT_REQ[0] |-> $past(TX_DATA_AVAIL[0]))
        else $error("bit request with nothing to send");
    req_single_a: assert property (TX_BIT_REQ[0] |=> !TX_BIT_REQ[0])
        else $error("bit request longer than one cycle");
    tx_pin_fall_a: assert property ($changed(LINE_TRANSMIT_PIN[0])
        |-> !$past(TX_CLK_PIN[0], 2)) else $error("transmit pin moved off the falling clock");
endmodule : tdmsr_router_sva
bind tdmsr_router tdmsr_router_sva u_sva (.CLOCK, .RST, .TX_CLK_PIN, .RX_SYNC_PIN,
    .LINE_TRANSMIT_PIN, .STROBE_PIN, .RESTART, .TX_DATA_AVAIL, .TX_BIT_REQ, .RX_BYTE,
    .RX_BYTE_CHAN, .RX_BYTE_HDLC, .RX_BYTE_VALID, .RX_BYTE_READY, .RX_SYNCED, .RX_OVERFLOW);

// File: bench/tdmsr_router_tb.sv
/*
 * tdmsr_router_tb: frame-level tests of the slot router against line models.
 * Assumes tables are written before the first sync and an 800 ns line clock.
 */
`timescale 1ns/1ps
module tdmsr_router_tb
    import tdmsr_pkg::*;
;
    localparam logic [23:0] FRM = 24'hA55A3C;
    logic        clk, rst = 1'b1, restart = 1'b0, tbl_we = 1'b0, tbl_tx = 1'b0;
    logic        tbl_tdm = 1'b0, chan_we = 1'b0, chan_act = 1'b0, chan_hdlc = 1'b0;
    logic        inv_rx = 1'b0, tx_bit = 1'b1, ready = 1'b0, rh, rv, ovf;
    logic [5:0]  tbl_addr = 6'h00, chan_addr = 6'h00, rch;
    logic [15:0] tbl_data = 16'h0000;
    logic [1:0]  avail = 2'b00, go = 2'b00, lclk, lsync, ldata, busy, txp, strb, synced, treq;
    logic [23:0] pbits [2] = '{24'h0, 24'h0};
    logic [4:0]  pn [2] = '{5'd0, 5'd0};
    logic [7:0]  rbyte;
    int          mismatches = 0, samples_checked = 0, strobe_n = 0, req_n = 0, n, f;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // both directions share each line model's clock and sync
    for (genvar g = 0; g < 2; g++) begin : g_line
        tdmsr_line_model u_line (.go(go[g]), .bits(pbits[g]), .nclk(pn[g]), .lclk(lclk[g]),
            .sync(lsync[g]), .data(ldata[g]), .busy(busy[g]));
    end
    tdmsr_router u_dut (
        .CLOCK(clk), .RST(rst), .RX_CLK_PIN(lclk), .TX_CLK_PIN(lclk),
        .RX_SYNC_PIN(lsync), .TX_SYNC_PIN(lsync), .LINE_RECEIVE_PIN(ldata),
        .LINE_TRANSMIT_PIN(txp), .STROBE_PIN(strb), .UNMUX_MODE(1'b0), .UNMUX_CD_PIN(1'b0),
        .UNMUX_CTS_PIN(1'b0), .RESTART(restart), .ECHO_EN(2'b00), .INV_TX(1'b0),
        .INV_RX(inv_rx), .TBL_WE(tbl_we), .TBL_TX(tbl_tx), .TBL_TDM(tbl_tdm),
        .TBL_ADDR(tbl_addr), .TBL_DATA(tbl_data), .CHAN_WE(chan_we), .CHAN_ADDR(chan_addr),
        .CHAN_ACTIVE(chan_act), .CHAN_HDLC(chan_hdlc), .TX_DATA_AVAIL(avail),
        .TX_BIT(tx_bit), .TX_BIT_REQ(treq), .TX_BIT_CHAN(), .RX_BYTE(rbyte), .RX_BYTE_CHAN(rch),
        .RX_BYTE_HDLC(rh), .RX_BYTE_VALID(rv), .RX_BYTE_READY(ready), .RX_SYNCED(synced),
        .RX_OVERFLOW(ovf)
    );
    // strobe lags the line clock fall by the synchroniser, so look at the next fall
    always @(negedge lclk[0]) begin
        if (strb[0] === 1'b1) strobe_n++;
    end
    always @(posedge clk) if (treq[0] === 1'b1) req_n++;
    task tick;
        @(posedge clk);
        #2;
    endtask : tick
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task chk_n(input int got, input int exp, input string what);
        samples_checked++;
        if (got != exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_n
    // one entry written to the receive table, then the transmit table
    task ent(input logic ln, input logic [5:0] a, input logic [15:0] d);
        tbl_tdm = ln;
        tbl_addr = a;
        tbl_data = d;
        tbl_we = 1'b1;
        for (int t = 0; t < 2; t++) begin
            tbl_tx = t[0];
            tick;
        end
        tbl_we = 1'b0;
    endtask : ent
    task chan(input logic [5:0] a, input logic act, input logic h);
        chan_addr = a;
        chan_act = act;
        chan_hdlc = h;
        chan_we = 1'b1;
        tick;
        chan_we = 1'b0;
    endtask : chan
    task frame(input int ln, input logic [23:0] b, input logic [4:0] nc);
        int k;
        pbits[ln] = b;
        pn[ln] = nc;
        strobe_n = 0;
        go[ln] = 1'b1;
        tick;
        go[ln] = 1'b0;
        k = 0;
        while (busy[ln] === 1'b1 && k < 600) begin
            tick;
            k++;
        end
        repeat (6) tick;
    endtask : frame
    // byte stays offered until ready is seen at a rising edge
    task take(input logic [7:0] b, input logic [5:0] ch, input logic h);
        int k;
        k = 0;
        while (rv !== 1'b1 && k < 300) begin
            tick;
            k++;
        end
        chk({7'h00, rv}, 8'h01, "valid");
        chk(rbyte, b, "byte");
        chk({2'b00, rch}, {2'b00, ch}, "channel");
        chk({7'h00, rh}, {7'h00, h}, "hdlc flag");
        ready = 1'b1;
        tick;
        ready = 1'b0;
    endtask : take
    task drain(output int cnt);
        int k;
        cnt = 0;
        k = 0;
        while (k < 40) begin
            tick;
            k++;
            if (rv === 1'b1) begin
                cnt++;
                ready = 1'b1;
                tick;
                ready = 1'b0;
                k = 0;
            end
        end
    endtask : drain
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // about twenty frames of some 210 cycles each; generous margin
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge clk);
        #2 rst = 1'b0;
        tick;
        chk({6'h00, txp}, 8'h03, "transmit idle");
        chk({4'h0, strb, synced}, 8'h00, "strobe and sync");
        chk({6'h00, rv, ovf}, 8'h00, "valid and overflow");
        // byte for ch5, 8 skipped bits, 8 strobed bits for ch9; line 1 one byte
        ent(1'b0, 6'h00, 16'h2005);
        ent(1'b0, 6'h01, 16'h09C0);
        ent(1'b0, 6'h02, 16'h51C9);
        ent(1'b1, 6'h00, 16'h6014);
        chan(6'h05, 1'b1, 1'b0);
        chan(6'h09, 1'b1, 1'b1);
        chan(6'h14, 1'b1, 1'b0);
        for (f = 0; f < 2; f++) begin
            inv_rx = f[0];
            frame(0, FRM, 5'd24);
            chk_n(strobe_n, 8, "strobed bits");
            take(8'hA5 ^ {8{f[0]}}, 6'h05, 1'b0);
            take(8'h3C ^ {8{f[0]}}, 6'h09, 1'b1);
        end
        inv_rx = 1'b0;
        chk({7'h00, synced[0]}, 8'h01, "synced");
        frame(1, 24'hC30000, 5'd8);
        take(8'hC3, 6'h14, 1'b0);
        // inactive channel yields nothing
        chan(6'h05, 1'b0, 1'b0);
        frame(0, FRM, 5'd24);
        take(8'h3C, 6'h09, 1'b1);
        drain(n);
        chk_n(n, 0, "bytes from idle channel");
        chan(6'h05, 1'b1, 1'b0);
        // loopback slot: transmitted zeros replace received ones
        ent(1'b0, 6'h02, 16'hD1C9);
        avail = 2'b01;
        tx_bit = 1'b0;
        frame(0, 24'hA55AFF, 5'd24);
        take(8'hA5, 6'h05, 1'b0);
        take(8'h00, 6'h09, 1'b1);
        chk_n(req_n, 16, "bit requests");
        ent(1'b0, 6'h02, 16'h51C9);
        avail = 2'b00;
        tx_bit = 1'b1;
        // one clock short: next sync ignored, routing correct again after that
        frame(0, FRM, 5'd23);
        frame(0, FRM, 5'd24);
        drain(n);
        chk_n(n, 2, "bytes around missed clock");
        frame(0, FRM, 5'd24);
        take(8'hA5, 6'h05, 1'b0);
        take(8'h3C, 6'h09, 1'b1);
        // reader stalls until the queue overflows, then drain and restart
        for (f = 0; f < FIFO_DEPTH / 2 + 2; f++) begin
            frame(0, FRM, 5'd24);
        end
        chk({7'h00, ovf}, 8'h01, "overflow");
        take(8'hA5, 6'h05, 1'b0);
        drain(n);
        restart = 1'b1;
        tick;
        restart = 1'b0;
        tick;
        chk({5'h00, ovf, synced}, 8'h00, "after restart");
        wrap_up;
    end
endmodule : tdmsr_router_tb
